// ---- design/sos_string_seq.sv ----
/*
 * String operation sequencer with its element FIFO.
 * Assumes memory and I/O partners answer a held request with a one-cycle ack,
 * and a register master that follows the plain strobe port protocol.
 */
// The plain strobed port and the placing of the registers were chosen for this implementation.
// Summary of operation
// R1: One element per iteration; element is byte, word or doubleword.
// R2: Source index uses the data segment unless an override picks another.
// R3: Destination index always uses the extra segment; overrides ignored.
// R4: Copy reads the source element and writes it to the destination.
// R5: Compare subtracts destination from source, sets six flags, writes nothing.
// R6: Scan subtracts destination from sized accumulator; memory and accumulator unchanged.
// R7: Load puts the source element into the sized accumulator part.
// R8: Store writes the sized accumulator part to the destination.
// R9: Each iteration steps the used index registers by one element size.
// R10: Direction flag zero increments indices, one decrements them.
// R11: Plain iterate repeats until count is zero, then finishes.
// R12: Iterate-while-equal continues while count nonzero and zero flag set.
// R13: Iterate-while-unequal continues while count nonzero and zero flag clear.
// R14: Conditional prefixes act only on compare and scan; other string ops iterate plainly, register port transfers run once.
// R15: Register port transfers move 32, 16 or 8 bits with the accumulator.
// R16: Register port transfers take the port from immediate or port index.
// R17: Block port transfers take the port only from the port index.
// R18: Block port transfers use index registers and repeat under the prefix.
// R19: Count drops by one per iteration, checked before each; zero skips.
`timescale 1ns/10ps

module sos_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] fill;
	logic push;
	logic pop;

	assign in_ready = fill != (PW+1)'(DEPTH);
	assign out_valid = fill != '0;
	assign out_data = store[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;

	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				fill <= fill + 1'b1;
			end else if (pop && !push) begin
				fill <= fill - 1'b1;
			end
		end
	end
endmodule

module sos_string_seq import sos_pkg::*; #(
	parameter int FIFO_D = FIFO_DEPTH
) (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic [REG_ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [31:0] MEM_WDATA,
	output logic [1:0] MEM_SIZE,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_ACK,
	output logic IO_REQ,
	output logic IO_WE,
	output logic [15:0] IO_PORT,
	output logic [31:0] IO_WDATA,
	output logic [1:0] IO_SIZE,
	input wire logic [31:0] IO_RDATA,
	input wire logic IO_ACK,
	output logic BUSY
);
	logic rst_meta;
	logic rst_n;
	sos_state_e state;
	sos_state_e next_state;
	sos_op_e op_sel;
	sos_pfx_e pfx_sel;
	logic [1:0] size_sel;
	logic [2:0] seg_sel;
	logic ovr_en;
	logic imm_sel;
	logic [15:0] imm_port;
	logic [15:0] port_index_register;
	logic [31:0] source_index;
	logic [31:0] destination_index;
	logic [31:0] count_register;
	logic [31:0] accumulator;
	logic [31:0] flag_word;
	logic [31:0] seg_base [NUM_SEG];
	logic [31:0] dst_val;
	logic done;
	logic wr_ok;
	logic start;
	logic [31:0] mask;
	logic [31:0] step_amt;
	logic [2:0] src_seg;
	logic [31:0] src_lin;
	logic [31:0] dst_lin;
	logic is_cs;
	logic reg_io;
	logic op_known;
	logic repeating;
	logic use_src;
	logic use_dst;
	logic fetch_mem;
	logic fetch_io;
	logic put_mem;
	logic put_io;
	logic from_acc;
	logic pop_at_step;
	logic mem_ack;
	logic io_ack;
	logic mem_go;
	logic io_go;
	logic [15:0] io_port_sel;
	logic [31:0] put_data;
	logic [5:0] res;
	logic stop_cond;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [31:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [31:0] fifo_out_data;
	logic [31:0] rdata_mux;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!rst_n);

	// Release is synchronous so no flop leaves reset on a different edge
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: size_mask = 32'h0000_00ff;
			SIZE_WORD: size_mask = 32'h0000_ffff;
			default: size_mask = 32'hffff_ffff;
		endcase
	endfunction

	// Result bits are {of, sf, zf, af, pf, cf} of a - b at the element width
	function automatic logic [5:0] sub_flags(input logic [31:0] a, input logic [31:0] b,
		input logic [1:0] sz);
		logic [31:0] m;
		logic [32:0] d;
		logic [31:0] msb;
		logic sa;
		logic sb;
		logic sd;
		m = size_mask(sz);
		d = {1'b0, a & m} - {1'b0, b & m};
		msb = (m >> 1) + 32'h0000_0001;
		sa = |(a & msb);
		sb = |(b & msb);
		sd = |(d[31:0] & msb);
		sub_flags = {(sa != sb) && (sd != sa), sd, (d[31:0] & m) == 32'h0000_0000,
			a[4] ^ b[4] ^ d[4], ~^d[7:0], d[32]};
	endfunction

	assign wr_ok = REG_WR && state == st_idle;
	assign start = wr_ok && REG_ADDR == OFS_CTRL && REG_WDATA[CTRL_START_BIT];
	assign mask = size_mask(size_sel); // R1 R15
	assign step_amt = (size_sel == SIZE_BYTE) ? 32'h0000_0001 :
		(size_sel == SIZE_WORD) ? 32'h0000_0002 : 32'h0000_0004; // R9
	assign src_seg = (ovr_en && seg_sel < 3'(NUM_SEG)) ? seg_sel : SEG_DATA; // R2
	assign src_lin = seg_base[src_seg] + source_index; // R2
	assign dst_lin = seg_base[SEG_EXTRA] + destination_index; // R3

	assign is_cs = op_sel == compare_element_op || op_sel == scan_element_op;
	assign reg_io = op_sel == port_in_op || op_sel == port_out_op;
	assign op_known = op_sel <= port_out_op;
	assign repeating = pfx_sel != no_prefix && !reg_io; // R18
	assign use_src = op_sel == copy_element_op || op_sel == compare_element_op ||
		op_sel == load_element_op || op_sel == memory_to_port_op;
	assign use_dst = op_sel == copy_element_op || is_cs || op_sel == store_element_op ||
		op_sel == port_to_memory_op;
	assign fetch_mem = use_src;
	assign fetch_io = op_sel == port_to_memory_op || op_sel == port_in_op;
	assign put_mem = op_sel == copy_element_op || op_sel == port_to_memory_op ||
		op_sel == store_element_op;
	assign put_io = op_sel == memory_to_port_op || op_sel == port_out_op;
	assign from_acc = op_sel == store_element_op || op_sel == port_out_op; // R8 R15
	assign pop_at_step = op_sel == compare_element_op || op_sel == load_element_op ||
		op_sel == port_in_op;
	// Block transfers never see the immediate port
	assign io_port_sel = (reg_io && imm_sel) ? imm_port : port_index_register; // R16 R17
	assign put_data = (from_acc ? accumulator : fifo_out_data) & mask;

	assign mem_ack = MEM_REQ && MEM_ACK;
	assign io_ack = IO_REQ && IO_ACK;
	assign res = sub_flags(op_sel == scan_element_op ? accumulator : fifo_out_data, dst_val,
		size_sel); // R5 R6
	assign stop_cond = is_cs && ((pfx_sel == iterate_while_equal && !res[3]) ||
		(pfx_sel == iterate_while_unequal && res[3])); // R12 R13 R14

	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (start) begin
					next_state = st_check;
				end
			end
			st_check: begin
				if (!op_known || (repeating && count_register == 32'h0000_0000)) begin
					next_state = st_idle; // R11 R19
				end else if (fetch_mem || fetch_io) begin
					next_state = st_fetch;
				end else if (op_sel == scan_element_op) begin
					next_state = st_fetch2;
				end else begin
					next_state = st_put;
				end
			end
			st_fetch: begin
				if (mem_ack || io_ack) begin
					if (op_sel == compare_element_op) begin
						next_state = st_fetch2;
					end else if (put_mem || put_io) begin
						next_state = st_put; // R4
					end else begin
						next_state = st_step;
					end
				end
			end
			st_fetch2: begin
				if (mem_ack) begin
					next_state = st_step;
				end
			end
			st_put: begin
				if (mem_ack || io_ack) begin
					next_state = st_step;
				end
			end
			st_step: begin
				next_state = (!repeating || stop_cond) ? st_idle : st_check; // R11 R14
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_idle;
			BUSY <= 1'b0;
		end else begin
			state <= next_state;
			BUSY <= next_state != st_idle;
		end
	end

	// Fetches wait for FIFO room, so a stalled drain holds the source back
	assign fifo_in_valid = state == st_fetch && (mem_ack || io_ack);
	assign fifo_in_data = (MEM_REQ ? MEM_RDATA : IO_RDATA) & mask; // R1
	assign fifo_pop = fifo_out_valid &&
		((state == st_put && !from_acc && (mem_ack || io_ack)) ||
		(state == st_step && pop_at_step));

	sos_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_fifo (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	assign mem_go = !MEM_REQ && ((state == st_fetch && fetch_mem && fifo_in_ready) ||
		state == st_fetch2 || (state == st_put && put_mem));

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= RST_WORD;
			MEM_WDATA <= RST_WORD;
			MEM_SIZE <= SIZE_BYTE;
		end else if (mem_go) begin
			MEM_REQ <= 1'b1;
			MEM_WE <= state == st_put; // R5 R6
			MEM_ADDR <= (state == st_fetch) ? src_lin : dst_lin; // R2 R3
			MEM_WDATA <= put_data; // R4 R8
			MEM_SIZE <= size_sel;
		end else if (mem_ack) begin
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
		end
	end

	assign io_go = !IO_REQ && ((state == st_fetch && fetch_io && fifo_in_ready) ||
		(state == st_put && put_io));

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			IO_REQ <= 1'b0;
			IO_WE <= 1'b0;
			IO_PORT <= 16'h0000;
			IO_WDATA <= RST_WORD;
			IO_SIZE <= SIZE_BYTE;
		end else if (io_go) begin
			IO_REQ <= 1'b1;
			IO_WE <= state == st_put;
			IO_PORT <= io_port_sel; // R16 R17
			IO_WDATA <= put_data; // R15
			IO_SIZE <= size_sel;
		end else if (io_ack) begin
			IO_REQ <= 1'b0;
			IO_WE <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			dst_val <= RST_WORD;
		end else if (state == st_fetch2 && mem_ack) begin
			dst_val <= MEM_RDATA & mask;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			op_sel <= copy_element_op;
			size_sel <= SIZE_BYTE;
			pfx_sel <= no_prefix;
			seg_sel <= SEG_DATA;
			ovr_en <= 1'b0;
			imm_sel <= 1'b0;
		end else if (wr_ok && REG_ADDR == OFS_CTRL) begin
			op_sel <= sos_op_e'(REG_WDATA[CTRL_OP_LSB +: 4]);
			size_sel <= REG_WDATA[CTRL_SIZE_LSB +: 2];
			pfx_sel <= sos_pfx_e'(REG_WDATA[CTRL_PFX_LSB +: 2]);
			seg_sel <= REG_WDATA[CTRL_SEG_LSB +: 3];
			ovr_en <= REG_WDATA[CTRL_OVR_BIT];
			imm_sel <= REG_WDATA[CTRL_IMM_BIT];
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			imm_port <= 16'h0000;
			port_index_register <= 16'h0000;
		end else if (wr_ok && REG_ADDR == OFS_IMM_PORT) begin
			imm_port <= REG_WDATA[15:0];
		end else if (wr_ok && REG_ADDR == OFS_PORT_IDX) begin
			port_index_register <= REG_WDATA[15:0];
		end
	end

	for (genvar g = 0; g < NUM_SEG; g++) begin : g_seg
		always_ff @(posedge SYS_CLK or negedge rst_n) begin
			if (!rst_n) begin
				seg_base[g] <= RST_WORD;
			end else if (wr_ok && REG_ADDR == OFS_SEG_BASE + 8'(4 * g)) begin
				seg_base[g] <= REG_WDATA;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			source_index <= RST_WORD;
		end else if (wr_ok && REG_ADDR == OFS_SRC) begin
			source_index <= REG_WDATA;
		end else if (state == st_step && use_src) begin
			source_index <= flag_word[FLAG_DF] ? source_index - step_amt :
				source_index + step_amt; // R9 R10
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			destination_index <= RST_WORD;
		end else if (wr_ok && REG_ADDR == OFS_DST) begin
			destination_index <= REG_WDATA;
		end else if (state == st_step && use_dst) begin
			destination_index <= flag_word[FLAG_DF] ? destination_index - step_amt :
				destination_index + step_amt; // R9 R10 R18
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			count_register <= RST_WORD;
		end else if (wr_ok && REG_ADDR == OFS_COUNT) begin
			count_register <= REG_WDATA;
		end else if (state == st_step && repeating) begin
			count_register <= count_register - 32'h0000_0001; // R19
		end
	end

	// Load and port input change only the sized part; scan never writes here
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			accumulator <= RST_WORD;
		end else if (wr_ok && REG_ADDR == OFS_ACC) begin
			accumulator <= REG_WDATA;
		end else if (state == st_step && (op_sel == load_element_op || op_sel == port_in_op)) begin
			accumulator <= (accumulator & ~mask) | (fifo_out_data & mask); // R7 R15
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flag_word <= RST_WORD;
		end else if (wr_ok && REG_ADDR == OFS_FLAGS) begin
			flag_word <= REG_WDATA & FLAG_WMASK;
		end else if (state == st_step && is_cs) begin
			flag_word[FLAG_CF] <= res[0]; // R5 R6
			flag_word[FLAG_PF] <= res[1];
			flag_word[FLAG_AF] <= res[2];
			flag_word[FLAG_ZF] <= res[3];
			flag_word[FLAG_SF] <= res[4];
			flag_word[FLAG_OF] <= res[5];
		end
	end

	// Start is only accepted in idle, so it never meets the setting edge
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else if (state != st_idle && next_state == st_idle) begin
			done <= 1'b1;
		end else if (start) begin
			done <= 1'b0;
		end
	end

	always_comb begin
		rdata_mux = 32'h0000_0000;
		case (REG_ADDR)
			OFS_CTRL: rdata_mux = {19'h0_0000, imm_sel, ovr_en, seg_sel, pfx_sel, size_sel, op_sel};
			OFS_SRC: rdata_mux = source_index;
			OFS_DST: rdata_mux = destination_index;
			OFS_COUNT: rdata_mux = count_register;
			OFS_ACC: rdata_mux = accumulator;
			OFS_PORT_IDX: rdata_mux = {16'h0000, port_index_register};
			OFS_FLAGS: rdata_mux = flag_word;
			OFS_STATUS: rdata_mux = {25'h000_0000, state, 2'h0, done, BUSY};
			OFS_IMM_PORT: rdata_mux = {16'h0000, imm_port};
			default: begin
				for (int i = 0; i < NUM_SEG; i++) begin
					if (REG_ADDR == OFS_SEG_BASE + 8'(4 * i)) begin
						rdata_mux = seg_base[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA <= RST_WORD;
		end else begin
			REG_RDATA <= REG_RD ? rdata_mux : RST_WORD;
		end
	end

	sequence s_cmp_step(sos_pfx_e p);
		state == st_step && is_cs && pfx_sel == p && count_register != 32'h0000_0001;
	endsequence

	a_src_default_seg: assert property ( // R2
		MEM_REQ && !MEM_WE && state == st_fetch && !ovr_en |->
		MEM_ADDR == seg_base[SEG_DATA] + source_index) else $error("source not in data segment");
	a_dst_extra_seg: assert property ( // R3
		MEM_REQ && MEM_WE |-> MEM_ADDR == seg_base[SEG_EXTRA] + destination_index)
		else $error("destination not in extra segment");
	a_copy_data_path: assert property ( // R4
		MEM_REQ && MEM_WE && op_sel == copy_element_op |-> MEM_WDATA == (fifo_out_data & mask))
		else $error("copy wrote other data");
	a_compare_no_write: assert property ( // R5
		MEM_REQ && is_cs |-> !MEM_WE) else $error("compare or scan wrote memory");
	a_scan_keeps_acc: assert property ( // R6
		state == st_step && op_sel == scan_element_op |=> $stable(accumulator))
		else $error("scan changed accumulator");
	a_load_fills_acc: assert property ( // R7
		state == st_step && op_sel == load_element_op |=>
		(accumulator & mask) == ($past(fifo_out_data) & mask)) else $error("load lost element");
	a_index_forward: assert property ( // R10
		state == st_step && use_src && !flag_word[FLAG_DF] |=>
		source_index == $past(source_index) + $past(step_amt)) else $error("bad increment");
	a_index_backward: assert property ( // R10
		state == st_step && use_dst && flag_word[FLAG_DF] |=>
		destination_index == $past(destination_index) - $past(step_amt))
		else $error("bad decrement");
	a_zero_count_skip: assert property ( // R19
		state == st_check && repeating && count_register == 32'h0000_0000 |=>
		state == st_idle ##1 !MEM_REQ && !IO_REQ) else $error("zero count iterated");
	a_count_per_iter: assert property ( // R19
		state == st_step && repeating |=> count_register == $past(count_register) - 32'h0000_0001)
		else $error("count not decremented");
	a_equal_stop: assert property ( // R12
		s_cmp_step(iterate_while_equal) ##1 !flag_word[FLAG_ZF] |-> state == st_idle)
		else $error("while-equal did not stop");
	a_unequal_go_on: assert property ( // R13
		s_cmp_step(iterate_while_unequal) ##1 !flag_word[FLAG_ZF] |-> state == st_check)
		else $error("while-unequal stopped early");
	a_block_port_index: assert property ( // R17
		IO_REQ && !reg_io |-> IO_PORT == port_index_register) else $error("block port wrong");
endmodule

// ---- include/sos_pkg.sv ----
/*
 * Shared constants and types for the string operation sequencer.
 * Assumes a 32-bit register port with byte addresses and one aligned word per register.
 */
package sos_pkg;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 16;
	localparam int REG_ADDR_W = 8;
	localparam int NUM_SEG = 6;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h04;
	localparam logic [7:0] OFS_DST = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_ACC = 8'h10;
	localparam logic [7:0] OFS_PORT_IDX = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_IMM_PORT = 8'h20;
	localparam logic [7:0] OFS_SEG_BASE = 8'h24;

	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_SIZE_LSB = 4;
	localparam int CTRL_PFX_LSB = 6;
	localparam int CTRL_SEG_LSB = 8;
	localparam int CTRL_OVR_BIT = 11;
	localparam int CTRL_IMM_BIT = 12;
	localparam int CTRL_START_BIT = 31;

	localparam int FLAG_CF = 0;
	localparam int FLAG_PF = 2;
	localparam int FLAG_AF = 4;
	localparam int FLAG_ZF = 6;
	localparam int FLAG_SF = 7;
	localparam int FLAG_DF = 10;
	localparam int FLAG_OF = 11;
	localparam logic [31:0] FLAG_WMASK = 32'h0000_0cd5;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_DWORD = 2'h2;

	localparam logic [2:0] SEG_EXTRA = 3'h0;
	localparam logic [2:0] SEG_DATA = 3'h3;

	typedef enum logic [3:0] {copy_element_op = 4'b0000, compare_element_op = 4'b0001,
		scan_element_op = 4'b0010, load_element_op = 4'b0011, store_element_op = 4'b0100,
		port_to_memory_op = 4'b0101, memory_to_port_op = 4'b0110, port_in_op = 4'b0111,
		port_out_op = 4'b1000} sos_op_e;
	typedef enum logic [1:0] {no_prefix = 2'b00, iterate_prefix = 2'b01,
		iterate_while_equal = 2'b10, iterate_while_unequal = 2'b11} sos_pfx_e;
	typedef enum logic [2:0] {st_idle = 3'b000, st_check = 3'b001, st_fetch = 3'b010,
		st_fetch2 = 3'b011, st_put = 3'b100, st_step = 3'b101} sos_state_e;
endpackage

// ---- test/sos_far_model.sv ----
/*
 * Memory and port space standing behind the sequencer.
 * Assumes one request at a time, held until the ack edge; lag sets the wait.
 */
`timescale 1ns/10ps

module sos_far_model (
	input wire logic SYS_CLK,
	input wire logic [1:0] lag,
	input wire logic MEM_REQ,
	input wire logic MEM_WE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic [31:0] MEM_WDATA,
	input wire logic [1:0] MEM_SIZE,
	output logic [31:0] MEM_RDATA,
	output logic MEM_ACK,
	input wire logic IO_REQ,
	input wire logic IO_WE,
	input wire logic [15:0] IO_PORT,
	input wire logic [31:0] IO_WDATA,
	input wire logic [1:0] IO_SIZE,
	output logic [31:0] IO_RDATA,
	output logic IO_ACK
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] io_data;
	logic [15:0] io_port;
	logic [1:0] mwait;
	logic [1:0] iwait;
	logic [1:0] mem_sz;
	logic [1:0] io_sz;
	initial begin
		{MEM_ACK, IO_ACK, mwait, iwait, io_data, io_port, mem_sz, io_sz} = '0;
		MEM_RDATA = 32'h5a5a_5a5a;
		IO_RDATA = 32'ha5a5_a5a5;
	end
	// Outside an ack the read lines toggle so a late sample never looks valid
	always @(posedge SYS_CLK) begin
		MEM_ACK <= 1'b0;
		MEM_RDATA <= ~MEM_RDATA;
		mwait <= MEM_REQ && !MEM_ACK ? mwait + 2'h1 : 2'h0;
		if (MEM_REQ && !MEM_ACK && mwait >= lag) begin
			MEM_ACK <= 1'b1;
			mwait <= 2'h0;
			mem_sz <= MEM_SIZE;
			if (MEM_WE)
				mem[MEM_ADDR] = MEM_WDATA;
			else
				MEM_RDATA <= mem.exists(MEM_ADDR) ? mem[MEM_ADDR] : ~MEM_ADDR;
		end
	end
	always @(posedge SYS_CLK) begin
		IO_ACK <= 1'b0;
		IO_RDATA <= ~IO_RDATA;
		iwait <= IO_REQ && !IO_ACK ? iwait + 2'h1 : 2'h0;
		if (IO_REQ && !IO_ACK && iwait >= lag) begin
			IO_ACK <= 1'b1;
			iwait <= 2'h0;
			io_sz <= IO_SIZE;
			if (IO_WE)
				{io_port, io_data} <= {IO_PORT, IO_WDATA};
			else
				IO_RDATA <= {16'hc3c3, IO_PORT};
		end
	end
endmodule

// ---- test/testbench.sv ----
/*
 * Self-checking bench: register tasks drive string runs against the far model.
 * Assumes the plain strobe register port and BUSY falling at the end of a run.
 */
`timescale 1ns/10ps

module testbench;
	import sos_pkg::*;
	logic clk = 0, rstn = 0, wr = 0, rd_s = 0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0, rdata, d, mrd, mwd, mad, ird, iwd;
	logic req, we, mack, ireq, iwe, iack, busy;
	logic [1:0] msz, isz, lag = 2'h0;
	logic [15:0] iport;
	int mismatches = 0, checks = 0;
	sos_string_seq u_sos_string_seq (.SYS_CLK(clk), .RSTN(rstn), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd_s), .REG_RDATA(rdata), .MEM_REQ(req),
		.MEM_WE(we), .MEM_ADDR(mad), .MEM_WDATA(mwd), .MEM_SIZE(msz), .MEM_RDATA(mrd),
		.MEM_ACK(mack), .IO_REQ(ireq), .IO_WE(iwe), .IO_PORT(iport), .IO_WDATA(iwd),
		.IO_SIZE(isz), .IO_RDATA(ird), .IO_ACK(iack), .BUSY(busy));
	sos_far_model u_sos_far_model (.SYS_CLK(clk), .lag(lag), .MEM_REQ(req), .MEM_WE(we),
		.MEM_ADDR(mad), .MEM_WDATA(mwd), .MEM_SIZE(msz), .MEM_RDATA(mrd), .MEM_ACK(mack),
		.IO_REQ(ireq), .IO_WE(iwe), .IO_PORT(iport), .IO_WDATA(iwd), .IO_SIZE(isz),
		.IO_RDATA(ird), .IO_ACK(iack));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, v};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		{rd_s, addr} <= {1'b1, a};
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
		chk($sformatf("reg %h", a), e & m, d & m);
	endtask
	// op, size, prefix, segment, override, immediate, count
	task automatic go(input int op, sz, pf, sg, ov, im, input logic [31:0] cnt);
		int n;
		wreg(OFS_COUNT, cnt);
		wreg(OFS_CTRL, 32'h8000_0000 | op | sz << 4 | pf << 6 | sg << 8 | ov << 11 | im << 12);
		@(posedge clk);
		#1;
		for (n = 0; n < 200 && busy !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		chk("run end", 32'h0, {31'h0, busy});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#(40 * 4000);
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rreg(OFS_CTRL, 32'h0000_0300, '1);
		rreg(OFS_FLAGS, 32'h0, '1);
		wreg(OFS_SEG_BASE, 32'h0000_2000);
		wreg(OFS_SEG_BASE + 8'h04, 32'h0000_7000);
		wreg(OFS_SEG_BASE + 8'h0c, 32'h0000_1000);
		wreg(OFS_SEG_BASE + 8'h10, 32'h0000_5000);
		u_sos_far_model.mem[32'h0000_1100] = 32'h1122_3344;
		u_sos_far_model.mem[32'h0000_1104] = 32'h5566_7788;
		lag <= 2'h2;
		wreg(OFS_SRC, 32'h0000_0100);
		wreg(OFS_DST, 32'h0000_0200);
		go(0, 2, 1, 3, 0, 0, 32'h2);
		chk("copy 0", 32'h1122_3344, u_sos_far_model.mem[32'h0000_2200]);
		chk("copy 1", 32'h5566_7788, u_sos_far_model.mem[32'h0000_2204]);
		chk("copy size", 32'h2, {30'h0, u_sos_far_model.mem_sz});
		rreg(OFS_SRC, 32'h0000_0108, '1);
		rreg(OFS_DST, 32'h0000_0208, '1);
		rreg(OFS_COUNT, 32'h0, '1);
		lag <= 2'h0;
		wreg(OFS_FLAGS, 32'h0000_0400);
		wreg(OFS_ACC, 32'haabb_ccdd);
		wreg(OFS_DST, 32'h0000_0210);
		go(4, 0, 1, 1, 1, 0, 32'h0);
		rreg(OFS_DST, 32'h0000_0210, '1);
		go(4, 0, 1, 1, 1, 0, 32'h1);
		chk("store", 32'h0000_00dd, u_sos_far_model.mem[32'h0000_2210]);
		rreg(OFS_DST, 32'h0000_020f, '1);
		u_sos_far_model.mem[32'h0000_5010] = 32'h0000_beef;
		wreg(OFS_SRC, 32'h0000_0010);
		go(3, 1, 0, 4, 1, 0, 32'h0);
		rreg(OFS_ACC, 32'h0000_beef, 32'h0000_ffff);
		rreg(OFS_SRC, 32'h0000_000e, '1);
		wreg(OFS_FLAGS, 32'h0);
		u_sos_far_model.mem[32'h0000_1300] = 32'h41;
		u_sos_far_model.mem[32'h0000_1301] = 32'h42;
		u_sos_far_model.mem[32'h0000_2400] = 32'h41;
		u_sos_far_model.mem[32'h0000_2401] = 32'h43;
		wreg(OFS_SRC, 32'h0000_0300);
		wreg(OFS_DST, 32'h0000_0400);
		go(1, 0, 2, 3, 0, 0, 32'h3);
		rreg(OFS_COUNT, 32'h1, '1);
		rreg(OFS_FLAGS, 32'h0000_0095, '1);
		chk("no write", 32'h43, u_sos_far_model.mem[32'h0000_2401]);
		wreg(OFS_ACC, 32'h1234_5643);
		wreg(OFS_DST, 32'h0000_0400);
		go(2, 0, 3, 3, 0, 0, 32'h3);
		rreg(OFS_COUNT, 32'h1, '1);
		rreg(OFS_DST, 32'h0000_0402, '1);
		rreg(OFS_FLAGS, 32'h0000_0044, '1);
		rreg(OFS_ACC, 32'h1234_5643, '1);
		wreg(OFS_IMM_PORT, 32'h0000_0077);
		wreg(OFS_PORT_IDX, 32'h0000_0123);
		go(7, 2, 0, 3, 0, 1, 32'h0);
		rreg(OFS_ACC, 32'hc3c3_0077, '1);
		go(7, 1, 0, 3, 0, 0, 32'h0);
		rreg(OFS_ACC, 32'h0000_0123, 32'h0000_ffff);
		wreg(OFS_SRC, 32'h0000_0100);
		go(6, 2, 1, 3, 0, 1, 32'h1);
		chk("out port", 32'h123, {16'h0, u_sos_far_model.io_port});
		chk("out data", 32'h1122_3344, u_sos_far_model.io_data);
		rreg(OFS_SRC, 32'h0000_0104, '1);
		chk("out size", 32'h2, {30'h0, u_sos_far_model.io_sz});
		wreg(OFS_DST, 32'h0000_0500);
		go(5, 1, 1, 3, 0, 1, 32'h1);
		chk("port to mem", 32'h0000_0123, u_sos_far_model.mem[32'h0000_2500]);
		chk("mem size", 32'h1, {30'h0, u_sos_far_model.mem_sz});
		rreg(OFS_DST, 32'h0000_0502, '1);
		go(8, 0, 0, 3, 0, 1, 32'h0);
		chk("out imm port", 32'h77, {16'h0, u_sos_far_model.io_port});
		chk("out byte", 32'h23, u_sos_far_model.io_data);
		chk("out byte size", 32'h0, {30'h0, u_sos_far_model.io_sz});
		rreg(OFS_STATUS, 32'h0000_0002, '1);
		give_verdict();
	end
endmodule
